// ==== shared/hmf_pkg.sv ====
package hmf_pkg;
  // Word indices; byte address is four times the index
  localparam logic [3:0] IDX_FLOW = 4'h8;
  localparam logic [3:0] IDX_TAG1 = 4'h9;
  localparam logic [3:0] IDX_TAG2 = 4'hA;
  localparam logic [3:0] IDX_WFP = 4'hB;
  localparam logic [3:0] IDX_CTRL = 4'hE;
  localparam logic [3:0] IDX_STAT = 4'hF;
  localparam int ADR_LSB = 2;
  localparam int ADR_W = 6;

  // Flow control register fields
  localparam int FLOW_BUSY_BIT = 0;
  localparam int FLOW_EN_BIT = 1;
  localparam int FLOW_PASS_BIT = 2;
  localparam int FLOW_QUANTA_LSB = 16;
  localparam logic [15:0] FLOW_QUANTA_RST = 16'h0000;

  // Tag registers
  localparam logic [15:0] TAG_RST = 16'hFFFF;

  // Control register fields
  localparam int CTRL_TXEN_BIT = 0;
  localparam int CTRL_FDX_BIT = 1;
  localparam int CTRL_SRST_BIT = 2;

  // Status register fields
  localparam int STAT_LEN_LSB = 0;
  localparam int STAT_HIT1_BIT = 16;
  localparam int STAT_HIT2_BIT = 17;
  localparam int STAT_PTR_LSB = 24;

  // Frame lengths in bytes, tag byte positions, byte counter limit
  localparam logic [10:0] LEN_PLAIN = 11'h5EE;
  localparam logic [10:0] LEN_TAG1 = 11'h5F2;
  localparam logic [10:0] LEN_TAG2 = 11'h602;
  localparam logic [3:0] TAG_HI_POS = 4'hC;
  localparam logic [3:0] TAG_LO_POS = 4'hD;
  localparam logic [3:0] CNT_SAT = 4'hE;

  // Wake filter
  localparam int WF_DEPTH = 8;
endpackage : hmf_pkg

// ==== core/hmf_wake_filter.sv ====
module hmf_wake_filter
  import hmf_pkg::*;
#(
  parameter int DEPTH = WF_DEPTH,
  parameter int PW = $clog2(WF_DEPTH)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic wr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [PW-1:0] rd_idx_i,
  output logic [31:0] rd_word_o,
  output logic [PW-1:0] ptr_o
);
  logic [PW-1:0] ptr_q;
  logic [31:0] mem_q [DEPTH];

  // Pointer clear has priority over a write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_i) begin
      ptr_q <= '0;
    end else if (wr_i) begin
      if (ptr_q == PW'(DEPTH - 1)) begin
        ptr_q <= '0;
      end else begin
        ptr_q <= ptr_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 32'h0000_0000;
      end
    end else if (wr_i) begin
      mem_q[ptr_q] <= wr_data_i;
    end
  end

  assign rd_word_o = mem_q[rd_idx_i];
  assign ptr_o = ptr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ptr_step;
    wr_i && !soft_rst_i && ptr_q != PW'(DEPTH - 1)
      |=> ptr_q == $past(ptr_q) + PW'(1);
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("filter pointer did not advance");

  property p_ptr_wrap;
    wr_i && !soft_rst_i && ptr_q == PW'(DEPTH - 1) |=> ptr_q == '0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap)
    else $error("filter pointer did not wrap");

  property p_soft_clr;
    soft_rst_i |=> ptr_q == '0;
  endproperty
  a_soft_clr: assert property (p_soft_clr)
    else $error("soft reset did not clear pointer");

  property p_store;
    wr_i && !soft_rst_i |=> mem_q[$past(ptr_q)] == $past(wr_data_i);
  endproperty
  a_store: assert property (p_store)
    else $error("filter word not stored");

  c_wrap: cover property (wr_i && ptr_q == PW'(DEPTH - 1));
endmodule : hmf_wake_filter

// ==== core/hmf_mac_ctl.sv ====
// Added by the designer: the Wishbone register port.
module hmf_mac_ctl
  import hmf_pkg::*;
#(
  parameter int PW = $clog2(WF_DEPTH)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pause frame request toward the fabric
  output logic pause_req_o,
  output logic [15:0] pause_quanta_o,
  input wire logic pause_done_i,
  output logic backpressure_o,
  // Receive byte stream for tag detection
  input wire logic rx_valid_i,
  input wire logic rx_sof_i,
  input wire logic [7:0] rx_data_i,
  output logic [10:0] max_len_o,
  output logic tag1_hit_o,
  output logic tag2_hit_o,
  // Filter readback for the matcher
  input wire logic [PW-1:0] wf_rd_idx_i,
  output logic [31:0] wf_word_o
);
  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] idx;
  logic req;
  logic wr_ev;
  logic busy_q;
  logic fc_en_q;
  logic fc_pass_q;
  logic [15:0] quanta_q;
  logic [15:0] tag1_q;
  logic [15:0] tag2_q;
  logic tx_en_q;
  logic fdx_q;
  logic srst_q;
  logic [3:0] cnt_q;
  logic [7:0] hi_q;
  logic [10:0] len_q;
  logic hit1_q;
  logic hit2_q;
  logic [PW-1:0] wf_ptr;
  logic wf_wr;
  logic [15:0] rx_tag;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [1:0] sel,
                                          input int lane);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = nw[lane*8 +: 8];
    end
    if (sel[1]) begin
      r[15:8] = nw[lane*8+8 +: 8];
    end
    return r;
  endfunction : merge16

  assign idx = wb_adr_i[ADR_LSB +: 4];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  // Write lands on the edge where the master samples ack
  assign wr_ev = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wf_wr = wr_ev && idx == IDX_WFP;

  // One wait state answer, every address acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req) begin
      case (idx)
        IDX_FLOW: begin
          dat_q <= {quanta_q, 13'h0000, fc_pass_q, fc_en_q, busy_q};
        end
        IDX_TAG1: begin
          dat_q <= {16'h0000, tag1_q};
        end
        IDX_TAG2: begin
          dat_q <= {16'h0000, tag2_q};
        end
        IDX_CTRL: begin
          dat_q <= {29'h0000_0000, 1'b0, fdx_q, tx_en_q};
        end
        IDX_STAT: begin
          dat_q <= {(8 - PW)'(0), wf_ptr, 6'h00, hit2_q, hit1_q,
                    5'h00, len_q};
        end
        // Filter port and unmapped words read as zero
        default: begin
          dat_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Plain storage of flow register fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quanta_q <= FLOW_QUANTA_RST;
      fc_en_q <= 1'b0;
      fc_pass_q <= 1'b0;
    end else if (wr_ev && idx == IDX_FLOW) begin
      quanta_q <= merge16(quanta_q, wb_dat_i, wb_sel_i[3:2], 2);
      if (wb_sel_i[0]) begin
        fc_en_q <= wb_dat_i[FLOW_EN_BIT];
        fc_pass_q <= wb_dat_i[FLOW_PASS_BIT];
      end
    end
  end

  // Busy: full duplex only software sets, completion clears; a set in the
  // completion cycle wins. Half duplex it is the backpressure level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (wr_ev && idx == IDX_FLOW && wb_sel_i[0]) begin
      if (fdx_q) begin
        if (wb_dat_i[FLOW_BUSY_BIT] && tx_en_q) begin
          busy_q <= 1'b1;
        end else if (pause_done_i && pause_req_o) begin
          busy_q <= 1'b0;
        end
      end else begin
        busy_q <= wb_dat_i[FLOW_BUSY_BIT];
      end
    end else if (fdx_q && pause_done_i && pause_req_o) begin
      busy_q <= 1'b0;
    end
  end

  // A pending pause waits while the transmitter is off
  assign pause_req_o = busy_q && fdx_q && tx_en_q;
  assign backpressure_o = busy_q && !fdx_q && tx_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_quanta_o <= FLOW_QUANTA_RST;
    end else begin
      pause_quanta_o <= quanta_q;
    end
  end

  // Tag identifiers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag1_q <= TAG_RST;
      tag2_q <= TAG_RST;
    end else if (wr_ev && idx == IDX_TAG1) begin
      tag1_q <= merge16(tag1_q, wb_dat_i, wb_sel_i[1:0], 0);
    end else if (wr_ev && idx == IDX_TAG2) begin
      tag2_q <= merge16(tag2_q, wb_dat_i, wb_sel_i[1:0], 0);
    end
  end

  // Own control: transmitter enable, duplex, self-clearing soft reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_q <= 1'b0;
      fdx_q <= 1'b0;
      srst_q <= 1'b0;
    end else if (wr_ev && idx == IDX_CTRL && wb_sel_i[0]) begin
      tx_en_q <= wb_dat_i[CTRL_TXEN_BIT];
      fdx_q <= wb_dat_i[CTRL_FDX_BIT];
      srst_q <= wb_dat_i[CTRL_SRST_BIT];
    end else begin
      srst_q <= 1'b0;
    end
  end

  // Byte counter saturates so long frames cost nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      hi_q <= 8'h00;
    end else if (rx_valid_i) begin
      if (rx_sof_i) begin
        cnt_q <= 4'h1;
      end else if (cnt_q != CNT_SAT) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (!rx_sof_i && cnt_q == TAG_HI_POS) begin
        hi_q <= rx_data_i;
      end
    end
  end

  assign rx_tag = {hi_q, rx_data_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= LEN_PLAIN;
      hit1_q <= 1'b0;
      hit2_q <= 1'b0;
    end else if (rx_valid_i && rx_sof_i) begin
      len_q <= LEN_PLAIN;
      hit1_q <= 1'b0;
      hit2_q <= 1'b0;
    end else if (rx_valid_i && cnt_q == TAG_LO_POS) begin
      if (rx_tag == tag1_q) begin
        len_q <= LEN_TAG1;
        hit1_q <= 1'b1;
      end else if (rx_tag == tag2_q) begin
        len_q <= LEN_TAG2;
        hit2_q <= 1'b1;
      end
    end
  end

  assign max_len_o = len_q;
  assign tag1_hit_o = hit1_q;
  assign tag2_hit_o = hit2_q;

  hmf_wake_filter #(
    .DEPTH(WF_DEPTH),
    .PW(PW)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(srst_q),
    .wr_i(wf_wr),
    .wr_data_i(wb_dat_i),
    .rd_idx_i(wf_rd_idx_i),
    .rd_word_o(wf_word_o),
    .ptr_o(wf_ptr)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_busy_hold;
    pause_req_o && !pause_done_i |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped before pause completed");

  property p_busy_clear;
    pause_req_o && pause_done_i && !(wr_ev && idx == IDX_FLOW)
      |=> !busy_q;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared after pause completed");

  property p_start;
    wr_ev && idx == IDX_FLOW && wb_sel_i[0] && wb_dat_i[0] && fdx_q
      && tx_en_q ##1 fdx_q && tx_en_q |-> pause_req_o;
  endproperty
  a_start: assert property (p_start)
    else $error("setting busy did not request a pause");

  property p_txoff;
    !tx_en_q |-> !pause_req_o && !backpressure_o;
  endproperty
  a_txoff: assert property (p_txoff)
    else $error("pause or backpressure with transmitter off");

  property p_bp;
    !fdx_q && tx_en_q |-> backpressure_o == busy_q;
  endproperty
  a_bp: assert property (p_bp)
    else $error("backpressure does not follow the bit");

  property p_quanta;
    pause_req_o ##1 pause_req_o |-> pause_quanta_o == $past(quanta_q);
  endproperty
  a_quanta: assert property (p_quanta)
    else $error("pause quanta not presented");

  property p_tag1;
    rx_valid_i && !rx_sof_i && cnt_q == TAG_LO_POS && rx_tag == tag1_q
      |=> len_q == LEN_TAG1 && hit1_q && !hit2_q;
  endproperty
  a_tag1: assert property (p_tag1)
    else $error("first tag match length wrong");

  property p_tag2;
    rx_valid_i && !rx_sof_i && cnt_q == TAG_LO_POS && rx_tag != tag1_q
      && rx_tag == tag2_q |=> len_q == LEN_TAG2 && hit2_q;
  endproperty
  a_tag2: assert property (p_tag2)
    else $error("second tag match length wrong");

  property p_plain;
    rx_valid_i && !rx_sof_i && cnt_q == TAG_LO_POS && rx_tag != tag1_q
      && rx_tag != tag2_q |=> len_q == LEN_PLAIN && !hit1_q && !hit2_q;
  endproperty
  a_plain: assert property (p_plain)
    else $error("untagged frame changed the length");

  property p_wfp_read;
    req && !wb_we_i && idx == IDX_WFP ##1 ack_q
      |-> wb_dat_o == 32'h0000_0000 && wf_ptr == $past(wf_ptr);
  endproperty
  a_wfp_read: assert property (p_wfp_read)
    else $error("filter port read not zero or moved pointer");

  property p_ack;
    req |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not one cycle");

  c_pause: cover property (pause_req_o ##[1:20] pause_done_i);
  c_bp: cover property (backpressure_o);
  c_tag1: cover property (!hit1_q ##1 hit1_q);
  c_tag2: cover property (!hit2_q ##1 hit2_q);
endmodule : hmf_mac_ctl

// ==== verif/hmf_fabric_model.sv ====
module hmf_fabric_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pause_req_i,
  input wire logic [7:0] dly_i,
  output logic pause_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // One done pulse per request; count runs past dly_i so no repeat
  always_ff @(posedge clk_i) begin
    if (rst_i || !pause_req_i) begin
      cnt_q <= 8'h00;
      pause_done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      pause_done_o <= (cnt_q == dly_i);
    end
  end
endmodule : hmf_fabric_model

// ==== verif/tb.sv ====
module tb
  import hmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, rxv, sof, ack, preq, bp, h1, h2, done;
  logic [5:0] adr;
  logic [3:0] sel, bsel;
  logic [31:0] wdat, rdat, rdq, wword;
  logic [15:0] quanta;
  logic [10:0] mlen;
  logic [7:0] rxd, dly;
  logic [2:0] widx;
  int fail_count = 0;
  int n_compared = 0;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  hmf_mac_ctl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pause_req_o(preq),
    .pause_quanta_o(quanta), .pause_done_i(done), .backpressure_o(bp),
    .rx_valid_i(rxv), .rx_sof_i(sof), .rx_data_i(rxd), .max_len_o(mlen),
    .tag1_hit_o(h1), .tag2_hit_o(h2), .wf_rd_idx_i(widx),
    .wf_word_o(wword));

  hmf_fabric_model i_fab (.clk_i(clk_i), .rst_i(rst_i), .pause_req_i(preq),
    .dly_i(dly), .pause_done_o(done));

  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until ack is seen; data taken at that edge
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= {i, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
    rdq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    wb(1'b0, i, 32'h00000000);
    chk(rdq, e);
  endtask : rd

  task automatic frame(input logic [7:0] b13, input logic [7:0] b14,
                       input logic [10:0] len, input logic e1,
                       input logic e2);
    for (int k = 1; k <= 16; k++) begin
      @(posedge clk_i);
      rxv <= 1'b1;
      sof <= (k == 1);
      rxd <= (k == 13) ? b13 : (k == 14) ? b14 : 8'h3C;
    end
    @(posedge clk_i);
    rxv <= 1'b0;
    @(posedge clk_i);
    chk({19'h0, h2, h1, mlen}, {19'h0, e2, e1, len});
  endtask : frame

  task automatic pause(input logic [7:0] d, input logic [15:0] q);
    int n;
    n = 0;
    dly <= d;
    do begin
      wb(1'b0, IDX_FLOW, 32'h00000000);
      n++;
    end while (rdq[0] !== 1'b0 && n < 20);
    if (rdq[0] !== 1'b0) begin
      fail_count++;
      give_verdict();
    end
    wb(1'b1, IDX_FLOW, {q, 16'h0001});
    @(posedge clk_i);
    chk({31'h0, preq}, 32'h00000001);
    @(posedge clk_i);
    chk({15'h0, preq, quanta}, {15'h0, 1'b1, q});
    if (d > 8'h00) begin
      rd(IDX_FLOW, {q, 16'h0001});
    end
    n = 0;
    while (preq !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (preq !== 1'b0) begin
      fail_count++;
      give_verdict();
    end
    rd(IDX_FLOW, {q, 16'h0000});
  endtask : pause

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'hF;
    bsel = 4'hF;
    wdat = 32'h00000000;
    rxv = 1'b0;
    sof = 1'b0;
    rxd = 8'h00;
    widx = 3'h0;
    dly = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_TAG1, 32'h0000FFFF);
    rd(IDX_TAG2, 32'h0000FFFF);
    rd(IDX_STAT, {21'h0, LEN_PLAIN});
    rd(4'h0, 32'h00000000);
    rd(IDX_WFP, 32'h00000000);
    // Nine writes: the ninth must land on entry 0 again
    for (int k = 0; k < 9; k++) begin
      wb(1'b1, IDX_WFP, 32'hA5000000 + k);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      widx <= k[2:0];
      @(posedge clk_i);
      chk(wword, (k == 0) ? 32'hA5000008 : 32'hA5000000 + k);
    end
    rd(IDX_WFP, 32'h00000000);
    rd(IDX_STAT, {8'h01, 13'h0, LEN_PLAIN});
    wb(1'b1, IDX_CTRL, 32'h00000004);
    rd(IDX_STAT, {21'h0, LEN_PLAIN});
    @(posedge clk_i);
    widx <= 3'h1;
    @(posedge clk_i);
    chk(wword, 32'hA5000001);
    wb(1'b1, IDX_TAG1, 32'h00008100);
    wb(1'b1, IDX_TAG2, 32'h000088A8);
    frame(8'h81, 8'h00, LEN_TAG1, 1'b1, 1'b0);
    frame(8'h88, 8'hA8, LEN_TAG2, 1'b0, 1'b1);
    frame(8'h08, 8'h00, LEN_PLAIN, 1'b0, 1'b0);
    wb(1'b1, IDX_TAG2, 32'h00008100);
    frame(8'h81, 8'h00, LEN_TAG1, 1'b1, 1'b0);
    // Upper byte lane only: low byte of the id must survive
    bsel = 4'h2;
    wb(1'b1, IDX_TAG1, 32'h000012EE);
    bsel = 4'hF;
    rd(IDX_TAG1, 32'h00001200);
    // Half duplex: bit is the backpressure enable
    wb(1'b1, IDX_CTRL, 32'h00000001);
    wb(1'b1, IDX_FLOW, 32'h00000001);
    @(posedge clk_i);
    chk({31'h0, bp}, 32'h00000001);
    rd(IDX_FLOW, 32'h00000001);
    wb(1'b1, IDX_CTRL, 32'h00000000);
    @(posedge clk_i);
    chk({31'h0, bp}, 32'h00000000);
    wb(1'b1, IDX_CTRL, 32'h00000001);
    wb(1'b1, IDX_FLOW, 32'h00000000);
    @(posedge clk_i);
    chk({31'h0, bp}, 32'h00000000);
    // Full duplex, transmitter off: start request is ignored
    wb(1'b1, IDX_CTRL, 32'h00000002);
    wb(1'b1, IDX_FLOW, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk({31'h0, preq}, 32'h00000000);
    rd(IDX_FLOW, 32'h00000000);
    wb(1'b1, IDX_CTRL, 32'h00000003);
    pause(8'h00, 16'h1234);
    pause(8'h05, 16'hBEEF);
    give_verdict();
  end
endmodule : tb
